// [inc/sac_pkg.sv]
/*
  Shared constants and types of the successive-approximation converter control.
  Assumes an 8-bit register port with byte-wide addresses.
*/
`default_nettype none
package sac_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // Register addresses
  localparam logic [7:0] SAC_ADDR_CFG = 8'haa;
  localparam logic [7:0] SAC_ADDR_CTRL = 8'had;
  localparam logic [7:0] SAC_ADDR_RES_LO = 8'hae;
  localparam logic [7:0] SAC_ADDR_RES_HI = 8'haf;
  localparam logic [7:0] SAC_ADDR_IRQ_STAT = 8'hb0;
  localparam logic [7:0] SAC_ADDR_IRQ_MASK = 8'hb1;
  ////////////////////////////////////////////////////////////////////////////
  // Control register fields
  localparam int SAC_CTRL_POWER_BIT = 7;
  localparam int SAC_CTRL_TRIG_BIT = 6;
  localparam int SAC_CTRL_DONE_BIT = 5;
  localparam int SAC_CTRL_CHAN_MSB = 4;
  // Configuration register fields
  localparam int SAC_CFG_LONG_BIT = 2;
  localparam int SAC_CFG_DIV_MSB = 1;
  // Interrupt status and mask fields
  localparam int SAC_IRQ_DONE_BIT = 0;
  localparam int SAC_IRQ_REJ_BIT = 1;
  localparam int SAC_IRQ_W = 2;
  ////////////////////////////////////////////////////////////////////////////
  // Channel codes
  localparam logic [4:0] SAC_CHAN_LAST_EXT = 5'h0f;
  localparam logic [4:0] SAC_CHAN_QUARTER = 5'h1f;
  localparam int SAC_EXT_CHANS = 16;
  // Divider settings and ratios
  localparam logic [1:0] SAC_DIV_SEL_12 = 2'h1;
  localparam logic [1:0] SAC_DIV_SEL_6 = 2'h2;
  localparam logic [3:0] SAC_DIV_RATIO_12 = 4'hc;
  localparam logic [3:0] SAC_DIV_RATIO_6 = 4'h6;
  // Converter clock counts of one conversion
  localparam logic [5:0] SAC_SAMPLE_SHORT = 6'h06;
  localparam logic [5:0] SAC_SAMPLE_LONG = 6'h24;
  localparam logic [5:0] SAC_CONV_CLKS = 6'h0e;
  localparam int SAC_RES_W = 12;
  localparam logic [5:0] SAC_DECISIONS = 6'h0c;
  // Result split over the two result registers
  localparam int SAC_RES_HI_LSB = 4;
  localparam int SAC_RES_LO_MSB = 3;
  localparam logic [3:0] SAC_RES_LO_PAD = 4'h0;
  ////////////////////////////////////////////////////////////////////////////
  // Sequencer states, Gray coded along idle-sample-convert-finish
  typedef enum logic [1:0] {
    SAC_ST_IDLE = 2'h0,
    SAC_ST_SAMPLE = 2'h1,
    SAC_ST_CONVERT = 2'h3,
    SAC_ST_FINISH = 2'h2
  } sac_state_t;
  // Control register image
  typedef struct packed {
    logic power_on;
    logic trigger;
    logic done;
    logic [4:0] chan;
  } sac_ctrl_t;
  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sac_req_t;
endpackage : sac_pkg
`default_nettype wire

// [src/sac_clk_div.sv]
/*
  Converter clock divider: turns the fast RC clock into a one-cycle tick.
  Assumes ref_clk is the fast RC clock and sel is steady during a conversion.
*/
`timescale 1ns/1ps
`default_nettype none
module sac_clk_div
  import sac_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic run,
  input wire logic [1:0] sel,
  output logic tick,
  output logic sel_ok
);
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [3:0] ratio;
  logic wrap;

  // Only two settings are defined; the others give no tick at all
  assign sel_ok = (sel == SAC_DIV_SEL_12) || (sel == SAC_DIV_SEL_6);
  assign ratio = (sel == SAC_DIV_SEL_12) ? SAC_DIV_RATIO_12 : SAC_DIV_RATIO_6;
  assign wrap = cnt_q == ratio - 4'h1;
  assign tick = run && sel_ok && wrap;
  assign cnt_d = (!run || wrap) ? 4'h0 : cnt_q + 4'h1;

  // Held at zero while idle so every conversion starts on a full period
  always_ff @(posedge ref_clk) begin
    if (reset) cnt_q <= 4'h0;
    else cnt_q <= cnt_d;
  end
endmodule : sac_clk_div
`default_nettype wire

// [src/sac_sar_core.sv]
/*
  Successive-approximation register: one bit decided per step, MSB first.
  Assumes keep reflects the comparator for the code now on trial.
*/
`timescale 1ns/1ps
`default_nettype none
module sac_sar_core
  import sac_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic start,
  input wire logic step,
  input wire logic keep,
  output logic [SAC_RES_W-1:0] trial
);
  logic [SAC_RES_W-1:0] bit_q;
  logic [SAC_RES_W-1:0] trial_q;
  logic [SAC_RES_W-1:0] trial_d;

  // Drop the bit on trial if the input is below, then try the next one
  assign trial_d = (keep ? trial_q : (trial_q & ~bit_q)) | (bit_q >> 1);
  assign trial = trial_q;

  // After the last step bit_q is empty and trial_q holds the result
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bit_q <= '0;
      trial_q <= '0;
    end else if (start) begin
      bit_q <= {1'b1, {(SAC_RES_W-1){1'b0}}};
      trial_q <= {1'b1, {(SAC_RES_W-1){1'b0}}};
    end else if (step && (bit_q != '0)) begin
      bit_q <= bit_q >> 1;
      trial_q <= trial_d;
    end
  end
endmodule : sac_sar_core
`default_nettype wire

// [src/sac_control.sv]
/*
  Control logic of a 12-bit successive-approximation converter: registers,
  sampling and conversion sequencer, channel routing and interrupt.
  Assumes ref_clk is the fast RC clock, comp_above comes from the analog
  comparator, and the analog mux, sample switch and DAC sit outside.
*/
// Behaviour
// - Control bit 7 switches converter power off when 0 and on when 1.
// - Writing 1 to control bit 6 with bit 7 set starts one conversion if idle with a valid divider; writing 0 does nothing.
// - A start trigger clears the completion flag in control bit 5.
// - The end of a conversion sets the completion flag.
// - Selector codes 0 to 15 route external input n to the converter.
// - Selector code 31 routes the quarter-supply internal channel.
// - The result is 12 bits by successive approximation over 16+1 channels.
// - A conversion is 6 or 36 sampling clocks then 14 conversion clocks.
// - Divider setting 01 divides by 12, 10 by 6, the others are reserved.
// - Result bits 11:4 read in the high register, 3:0 in the low upper nibble.
`timescale 1ns/1ps
`default_nettype none
module sac_control
  import sac_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic irq,
  output logic converter_power_on,
  output logic [SAC_EXT_CHANS-1:0] analog_input_select,
  output logic quarter_supply_select,
  output logic sample_hold,
  output logic [SAC_RES_W-1:0] trial_code,
  input wire logic comp_above
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  sac_req_t req;
  sac_ctrl_t ctrl_q;
  sac_ctrl_t ctrl_rd;
  sac_state_t state_q;
  sac_state_t state_d;
  logic power_q;
  logic done_q;
  logic done_d;
  logic [4:0] chan_q;
  logic long_q;
  logic [1:0] div_q;
  logic [SAC_RES_W-1:0] result_q;
  logic [SAC_IRQ_W-1:0] stat_q;
  logic [SAC_IRQ_W-1:0] stat_d;
  logic [SAC_IRQ_W-1:0] mask_q;
  logic [SAC_IRQ_W-1:0] evt;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [5:0] cnt_q;
  logic [5:0] cnt_d;
  logic comp_meta_q;
  logic comp_sync_q;
  logic wr_ctrl;
  logic wr_cfg;
  logic wr_stat;
  logic wr_mask;
  logic trig_wr;
  logic trig_ok;
  logic busy;
  logic tick;
  logic div_ok;
  logic [5:0] sample_len;
  logic last_sample;
  logic last_conv;
  logic finish;
  logic sar_step;
  logic [SAC_RES_W-1:0] sar_trial;

  // Decoded address match, shared by the four write decodes
  function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_a);
    hit = a == reg_a;
  endfunction : hit

  // Phase counter arithmetic, shared by both phases
  function automatic logic [5:0] cnt_next(input logic [5:0] v);
    cnt_next = v + 6'h01;
  endfunction : cnt_next

  function automatic logic cnt_at_end(input logic [5:0] v, input logic [5:0] len);
    cnt_at_end = v == len - 6'h01;
  endfunction : cnt_at_end

  ////////////////////////////////////////////////////////////////////////////
  // Register port decode
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign wr_ctrl = req.wr && hit(req.addr, SAC_ADDR_CTRL);
  assign wr_cfg = req.wr && hit(req.addr, SAC_ADDR_CFG);
  assign wr_stat = req.wr && hit(req.addr, SAC_ADDR_IRQ_STAT);
  assign wr_mask = req.wr && hit(req.addr, SAC_ADDR_IRQ_MASK);

  // Start request; power may be switched on in the same write
  assign trig_wr = wr_ctrl && req.wdata[SAC_CTRL_TRIG_BIT];
  assign trig_ok = trig_wr && req.wdata[SAC_CTRL_POWER_BIT] && !busy && div_ok;
  assign busy = state_q != SAC_ST_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  // Control register
  // Writing 0 to the flag leaves the status bit alone; each is cleared apart
  // Software may write the flag; the end of conversion wins over any clear
  assign done_d = finish ? 1'b1 :
                  trig_wr ? 1'b0 :
                  wr_ctrl ? req.wdata[SAC_CTRL_DONE_BIT] : done_q;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      power_q <= 1'b0;
      done_q <= 1'b0;
      chan_q <= 5'h00;
    end else begin
      done_q <= done_d;
      if (wr_ctrl) begin
        power_q <= req.wdata[SAC_CTRL_POWER_BIT];
        chan_q <= req.wdata[SAC_CTRL_CHAN_MSB:0];
      end
    end
  end

  // The trigger is not stored, so it reads as zero
  assign ctrl_q = '{power_on: power_q, trigger: 1'b0, done: done_q, chan: chan_q};
  assign converter_power_on = power_q;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration register: sample length and divider
  // Changing it mid-conversion alters the running conversion; software waits
  // Reserved divider codes are stored as written so software reads them back
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      long_q <= 1'b0;
      div_q <= 2'h0;
    end else if (wr_cfg) begin
      long_q <= req.wdata[SAC_CFG_LONG_BIT];
      div_q <= req.wdata[SAC_CFG_DIV_MSB:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Converter clock
  // Runs only while busy; an idle converter costs no divider toggling
  sac_clk_div u_div (
    .ref_clk(ref_clk),
    .reset(reset),
    .run(busy),
    .sel(div_q),
    .tick(tick),
    .sel_ok(div_ok)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Comparator synchroniser; the analog side is not on ref_clk
  // Two flops cost two cycles, far below one converter clock period
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      comp_meta_q <= 1'b0;
      comp_sync_q <= 1'b0;
    end else begin
      comp_meta_q <= comp_above;
      comp_sync_q <= comp_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: counts converter clocks of the sample and convert phases
  // The counter restarts at each phase change, so one compare serves each phase
  assign sample_len = long_q ? SAC_SAMPLE_LONG : SAC_SAMPLE_SHORT;
  assign last_sample = tick && cnt_at_end(cnt_q, sample_len);
  assign last_conv = tick && cnt_at_end(cnt_q, SAC_CONV_CLKS);
  // The first twelve convert clocks decide bits, the last two settle
  assign sar_step = (state_q == SAC_ST_CONVERT) && tick && (cnt_q < SAC_DECISIONS);
  assign finish = state_q == SAC_ST_FINISH;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      SAC_ST_IDLE: begin
        cnt_d = 6'h00;
        if (trig_ok) state_d = SAC_ST_SAMPLE;
      end
      SAC_ST_SAMPLE: begin
        if (last_sample) begin
          state_d = SAC_ST_CONVERT;
          cnt_d = 6'h00;
        end else if (tick) begin
          cnt_d = cnt_next(cnt_q);
        end
      end
      SAC_ST_CONVERT: begin
        if (last_conv) begin
          state_d = SAC_ST_FINISH;
          cnt_d = 6'h00;
        end else if (tick) begin
          cnt_d = cnt_next(cnt_q);
        end
      end
      SAC_ST_FINISH: begin
        state_d = SAC_ST_IDLE;
        cnt_d = 6'h00;
      end
      default: begin
        state_d = SAC_ST_IDLE;
        cnt_d = 6'h00;
      end
    endcase
  end

  // Switching power off abandons a conversion with no result; a write that
  // powers up and triggers together must not be held back by the old power bit
  always_ff @(posedge ref_clk) begin
    if (reset || (!power_q && !trig_ok)) begin
      state_q <= SAC_ST_IDLE;
      cnt_q <= 6'h00;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Successive approximation
  sac_sar_core u_sar (
    .ref_clk(ref_clk),
    .reset(reset),
    .start(trig_ok),
    .step(sar_step),
    .keep(comp_sync_q),
    .trial(sar_trial)
  );
  assign trial_code = sar_trial;

  // Result is captured only when a conversion completes
  always_ff @(posedge ref_clk) begin
    if (reset) result_q <= '0;
    else if (finish) result_q <= sar_trial;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog routing; reserved codes connect nothing
  // Routing follows the selector even when idle, so the input settles early
  assign analog_input_select = (power_q && (chan_q <= SAC_CHAN_LAST_EXT)) ?
      (SAC_EXT_CHANS'(1) << chan_q[3:0]) : '0;
  assign quarter_supply_select = power_q && (chan_q == SAC_CHAN_QUARTER);
  assign sample_hold = state_q == SAC_ST_SAMPLE;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status: sticky, write one to clear, new event wins
  assign evt[SAC_IRQ_DONE_BIT] = finish;
  // A trigger that cannot start is flagged so software knows it was lost
  assign evt[SAC_IRQ_REJ_BIT] = trig_wr && !trig_ok;
  assign stat_d = evt | (stat_q & ~(wr_stat ? req.wdata[SAC_IRQ_W-1:0] : '0));

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stat_q <= '0;
      mask_q <= '0;
    end else begin
      stat_q <= stat_d;
      if (wr_mask) mask_q <= req.wdata[SAC_IRQ_W-1:0];
    end
  end

  // Level output, high while any unmasked event is pending
  assign irq = |(stat_q & mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered one cycle after the strobe
  // Result registers have no write decode, so writes to them are dropped
  always_comb begin
    rdata_d = 8'h00;
    ctrl_rd = ctrl_q;
    case (req.addr)
      SAC_ADDR_CTRL: rdata_d = ctrl_rd;
      SAC_ADDR_CFG: rdata_d = {5'h00, long_q, div_q};
      SAC_ADDR_RES_HI: rdata_d = result_q[SAC_RES_W-1:SAC_RES_HI_LSB];
      SAC_ADDR_RES_LO: rdata_d = {result_q[SAC_RES_LO_MSB:0], SAC_RES_LO_PAD};
      SAC_ADDR_IRQ_STAT: rdata_d = {6'h00, stat_q};
      SAC_ADDR_IRQ_MASK: rdata_d = {6'h00, mask_q};
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) rdata_q <= 8'h00;
    else if (req.rd) rdata_q <= rdata_d;
    else rdata_q <= 8'h00;
  end
  assign reg_rdata = rdata_q;

endmodule : sac_control
`default_nettype wire

// [bench/sac_control_monitor.sv]
/*
  Port checker for the converter control block.
  Assumes it is bound to sac_control and sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none
module sac_control_monitor
  import sac_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic irq,
  input wire logic converter_power_on,
  input wire logic [SAC_EXT_CHANS-1:0] analog_input_select,
  input wire logic quarter_supply_select,
  input wire logic sample_hold,
  input wire logic [SAC_RES_W-1:0] trial_code,
  input wire logic comp_above
);
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  //////////////////////////////////////////////////////////////////////////////
  // Input routing
  a_mux_needs_power: assert property (
    !converter_power_on |-> analog_input_select == 16'h0 && !quarter_supply_select)
    else $error("input routed while powered off");
  a_one_input: assert property ($onehot0(analog_input_select))
    else $error("more than one external input routed");
  a_quarter_alone: assert property (
    quarter_supply_select |-> analog_input_select == 16'h0)
    else $error("quarter supply routed beside an external input");
  //////////////////////////////////////////////////////////////////////////////
  // Read data: one cycle only, trigger and padding read as zero
  a_rdata_quiet: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  a_trig_reads_zero: assert property (
    reg_rd && reg_addr == SAC_ADDR_CTRL |=> reg_rdata[SAC_CTRL_TRIG_BIT] == 1'b0)
    else $error("trigger bit read back as one");
  a_low_pad_zero: assert property (
    reg_rd && reg_addr == SAC_ADDR_RES_LO |=> reg_rdata[3:0] == 4'h0)
    else $error("low result nibble not zero");
  a_unmapped_zero: assert property (
    reg_rd && reg_addr < SAC_ADDR_CFG |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  //////////////////////////////////////////////////////////////////////////////
  // Sampling starts only from a powered trigger write, at the midpoint code
  a_start_cause: assert property (
    $rose(sample_hold) |-> $past(reg_wr) && $past(reg_addr) == SAC_ADDR_CTRL
    && ($past(reg_wdata) & 8'h40) != 8'h00)
    else $error("sampling began without a trigger write");
  a_start_powered: assert property ($rose(sample_hold) |-> converter_power_on)
    else $error("sampling began while powered off");
  a_start_msb: assert property ($rose(sample_hold) |-> trial_code == 12'h800)
    else $error("first trial code is not the midpoint");
  a_power_idle: assert property (
    !converter_power_on && !reg_wr |=> !sample_hold)
    else $error("sampling while powered off");
endmodule : sac_control_monitor
`default_nettype wire

// [bench/sac_control_tb.sv]
/*
  Self-checking bench for the converter control block.
  Assumes the bench is bus master and models the analog comparator.
*/
`timescale 1ns/1ps
`default_nettype none
module sac_control_tb
  import sac_pkg::*;
;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic irq, converter_power_on, quarter_supply_select, sample_hold;
  logic [15:0] analog_input_select;
  logic [11:0] trial_code;
  logic [11:0] target = 12'ha5c;
  wire logic comp_above;
  int n_errors = 0;
  int check_count = 0;
  // Analog level sits just above target; unknown codes compare low
  assign comp_above = (trial_code <= target) === 1'b1;
  sac_control u_dut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq(irq), .converter_power_on(converter_power_on),
    .analog_input_select(analog_input_select),
    .quarter_supply_select(quarter_supply_select), .sample_hold(sample_hold),
    .trial_code(trial_code), .comp_above(comp_above));
  // 250 MHz clock
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("Checks %0d, errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Strobes last one cycle; the next call starts a cycle later
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk(16'(reg_rdata), 16'(e));
  endtask : rd
  // Bounded wait for the interrupt, counting cycles
  task automatic wait_irq(output int n);
    n = 0;
    while (irq !== 1'b1) begin
      @(negedge ref_clk);
      n++;
      if (n > 2000) begin
        n_errors++;
        $display("Error at %0t: no completion", $time);
        final_report();
      end
    end
  endtask : wait_irq
  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    int n;
    int c;
    int e;
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    rd(SAC_ADDR_CTRL, 8'h00);
    rd(SAC_ADDR_CFG, 8'h00);
    rd(8'ha0, 8'h00);
    // Every external code, then quarter supply, then power off
    for (c = 0; c < 16; c++) begin
      wr(SAC_ADDR_CTRL, 8'h80 | 8'(c));
      @(negedge ref_clk);
      chk(analog_input_select, 16'h1 << c);
      rd(SAC_ADDR_CTRL, 8'h80 | 8'(c));
    end
    wr(SAC_ADDR_CTRL, 8'h9f);
    @(negedge ref_clk);
    chk({analog_input_select[14:0], quarter_supply_select}, 16'h1);
    wr(SAC_ADDR_CTRL, 8'h1f);
    @(negedge ref_clk);
    chk({14'h0, converter_power_on, quarter_supply_select}, 16'h0);
    // Reserved divider refuses the trigger and flags it
    wr(SAC_ADDR_CTRL, 8'hc3);
    @(negedge ref_clk);
    chk(16'(sample_hold), 16'h0);
    rd(SAC_ADDR_IRQ_STAT, 8'h02);
    wr(SAC_ADDR_IRQ_STAT, 8'h02);
    rd(SAC_ADDR_IRQ_STAT, 8'h00);
    // A zero in the trigger bit starts nothing
    wr(SAC_ADDR_CFG, 8'h02);
    wr(SAC_ADDR_CTRL, 8'h83);
    @(negedge ref_clk);
    chk(16'(sample_hold), 16'h0);
    wr(SAC_ADDR_IRQ_MASK, 8'h01);
    // Short sample at /6, then long sample at /12 with done still set
    for (c = 0; c < 2; c++) begin
      target = c ? 12'h3c1 : 12'ha5c;
      e = c ? 599 : 119;
      wr(SAC_ADDR_CFG, c ? 8'h05 : 8'h02);
      wr(SAC_ADDR_CTRL, 8'hc3);
      rd(SAC_ADDR_CTRL, 8'h83);
      wait_irq(n);
      chk(16'(n >= e - 3 && n <= e + 3), 16'h1);
      rd(SAC_ADDR_CTRL, 8'ha3);
      rd(SAC_ADDR_RES_HI, target[11:4]);
      rd(SAC_ADDR_RES_LO, {target[3:0], 4'h0});
      wr(SAC_ADDR_IRQ_STAT, 8'h01);
      @(negedge ref_clk);
      chk(16'(irq), 16'h0);
    end
    // Software clears the flag; result registers ignore writes
    wr(SAC_ADDR_CTRL, 8'h83);
    rd(SAC_ADDR_CTRL, 8'h83);
    wr(SAC_ADDR_RES_HI, 8'hff);
    rd(SAC_ADDR_RES_HI, 8'h3c);
    // Power and trigger in one write; a trigger while busy is refused
    wr(SAC_ADDR_CTRL, 8'h03);
    target = 12'h6e7;
    wr(SAC_ADDR_CTRL, 8'hc3);
    wr(SAC_ADDR_CTRL, 8'hc3);
    rd(SAC_ADDR_IRQ_STAT, 8'h02);
    wait_irq(n);
    chk(16'(n >= 594 && n <= 600), 16'h1);
    rd(SAC_ADDR_RES_HI, target[11:4]);
    rd(SAC_ADDR_RES_LO, {target[3:0], 4'h0});
    // Power off mid-conversion abandons it with no completion
    wr(SAC_ADDR_IRQ_STAT, 8'h03);
    wr(SAC_ADDR_CTRL, 8'hc3);
    wr(SAC_ADDR_CTRL, 8'h03);
    repeat (700) @(negedge ref_clk);
    chk(16'(irq), 16'h0);
    rd(SAC_ADDR_CTRL, 8'h03);
    rd(SAC_ADDR_IRQ_STAT, 8'h00);
    final_report();
  end
endmodule : sac_control_tb
bind sac_control sac_control_monitor u_mon (.ref_clk(ref_clk), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .irq(irq), .converter_power_on(converter_power_on),
  .analog_input_select(analog_input_select),
  .quarter_supply_select(quarter_supply_select), .sample_hold(sample_hold),
  .trial_code(trial_code), .comp_above(comp_above));
`default_nettype wire
